// ===== src/motion_seq_pkg.sv
// Package of constants and types for the motion sequencing block
package motion_seq_pkg;

  // ==========================================================================
  // Sizes and timing
  localparam int AXES_MAX       = 4;
  localparam int ERR_W          = 16;
  localparam int DIST_W         = 24;
  localparam int CLK_HZ         = 40000000;
  localparam int INPOS_OFF_US   = 4000;
  localparam int INPOS_OFF_CYC  = (CLK_HZ / 1000000) * INPOS_OFF_US;
  localparam int CNT_W          = 18;

  // ==========================================================================
  // Operating modes and command kinds
  typedef enum logic [1:0] {MODE_PASS, MODE_STOP, MODE_INPOS_OFF} op_mode_e;

  typedef enum logic [3:0] {
    CMD_RAPID_POSITIONING,
    CMD_LINEAR,
    CMD_CIRCULAR,
    CMD_REFERENCE_ORIGIN_RETURN,
    CMD_WORKPIECE_ORIGIN_RETURN,
    CMD_ORIGIN_SEARCH,
    CMD_SPEED_CONTROL,
    CMD_INTERRUPT_FEED,
    CMD_TRAVERSE,
    CMD_PASS_MODE,
    CMD_STOP_MODE,
    CMD_INPOS_CHECK_OFF,
    CMD_PROGRAM_START,
    CMD_UNIT_RESTART
  } cmd_e;

  // ==========================================================================
  // Block request from the program sequencer
  typedef struct packed {
    cmd_e                    cmd;
    logic [AXES_MAX-1:0]     axis_sel;
    logic                    two_stage;
    logic                    skip_opt;
    logic [DIST_W-1:0]       feed_dist;
    logic [DIST_W-1:0]       max_travel;
  } block_req_s;

  // Per-axis drive command
  typedef struct packed {
    logic                    speed_ctl;
    logic                    speed_stage2;
    logic                    pos_ctl;
    logic [DIST_W-1:0]       pos_target;
  } axis_drive_s;

endpackage

// ===== src/trig_sync.sv
// Two-stage synchroniser with rising-edge detect for trigger inputs
`timescale 1ns/100ps
module trig_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] rise_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] rise;
  } sync_state_s;

  sync_state_s st;
  sync_state_s next_st;

  always_comb
  begin
    next_st      = st;
    next_st.meta = async_in;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
    next_st.rise = st.sync & ~st.prev;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rise_out = st.rise;

endmodule

// ===== src/motion_sequencer.sv
// Block sequencer: operating modes, in-position judging and interrupt feeding
// Overview of operation
// - Interrupt feeding drives one axis in speed control until its trigger, then positions a fixed distance.
// - Before the trigger the speed reference is either single constant or a two-stage profile.
// - With no trigger within the travel limit the axis stops and aborts with error, or moves on if skip is set.
// - An interrupt feed block must name exactly one axis, otherwise it is refused with an error.
// - General inputs 1 to 4 trigger axes X, Y, Z and U in that order; a two-axis build uses inputs 1 and 2.
// - Three operating modes exist, stop, pass and in-position check off, each set by its own command.
// - Stop mode starts the next block only after positioning is judged complete.
// - Pass mode moves into the next block without checking positioning completion.
// - In-position check off mode acts as stop mode but starts the next block without judging completion.
// - A selected mode holds until another mode-changing event or command.
// - Reset, unit restart, program start and the origin search and return commands force pass mode.
// - Rapid positioning, origin commands, speed control and interrupt feeding always run in stop mode.
// - Positioning is complete when every axis error count lies within the in-position zone.
// - With the in-position check off the next block starts within 4 ms.
`timescale 1ns/100ps
module motion_sequencer #(
  parameter int AXES             = motion_seq_pkg::AXES_MAX,
  parameter int INPOS_OFF_CYCLES = motion_seq_pkg::INPOS_OFF_CYC
) (
  input  wire logic                                           sys_clk_in,
  input  wire logic                                           reset_in,
  input  wire logic                                           block_valid_in,
  input  wire motion_seq_pkg::block_req_s                     block_in,
  input  wire logic [motion_seq_pkg::ERR_W-1:0]               inpos_zone_in,
  input  wire logic [AXES-1:0][motion_seq_pkg::ERR_W-1:0]     err_count_in,
  input  wire logic [AXES-1:0][motion_seq_pkg::DIST_W-1:0]    axis_pos_in,
  input  wire logic [AXES-1:0]                                motion_done_in,
  input  wire logic [AXES-1:0]                                general_in,
  output logic                                                block_ready_out,
  output logic                                                block_done_out,
  output logic                                                prog_abort_out,
  output logic [1:0]                                          op_mode_out,
  output motion_seq_pkg::axis_drive_s [AXES-1:0]              drive_out
);

  // ==========================================================================
  // Elaboration checks
  if (AXES != 2 && AXES != motion_seq_pkg::AXES_MAX)
  begin
    $error("AXES must be 2 or 4");
  end
  if (INPOS_OFF_CYCLES < 1 || INPOS_OFF_CYCLES >= (1 << motion_seq_pkg::CNT_W))
  begin
    $error("INPOS_OFF_CYCLES out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_MOVE, ST_FEED_SPEED, ST_FEED_POS, ST_SETTLE} seq_e;

  typedef struct packed {
    seq_e                                       seq;
    motion_seq_pkg::op_mode_e                   mode;
    motion_seq_pkg::op_mode_e                   blk_mode;
    motion_seq_pkg::block_req_s                 blk;
    logic                                       trig_seen;
    logic                                       ready;
    logic                                       done;
    logic                                       abort;
    logic [motion_seq_pkg::CNT_W-1:0]           wait_cnt;
    motion_seq_pkg::axis_drive_s [AXES-1:0]     drive;
  } seq_state_s;

  seq_state_s st;
  seq_state_s next_st;
  logic [AXES-1:0] trig_rise;

  // ==========================================================================
  // Trigger synchronisation
  // sync and edge
  trig_sync #(.WIDTH(AXES)) u_trig_sync (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .async_in   (general_in),
    .rise_out   (trig_rise)
  );

  function automatic logic one_hot(input logic [AXES-1:0] v);
    return (v != '0) && ((v & (v - 1'b1)) == '0);
  endfunction

  function automatic logic forced_stop(input motion_seq_pkg::cmd_e c);
    return c inside {motion_seq_pkg::CMD_RAPID_POSITIONING,
                     motion_seq_pkg::CMD_REFERENCE_ORIGIN_RETURN,
                     motion_seq_pkg::CMD_WORKPIECE_ORIGIN_RETURN,
                     motion_seq_pkg::CMD_ORIGIN_SEARCH,
                     motion_seq_pkg::CMD_SPEED_CONTROL,
                     motion_seq_pkg::CMD_INTERRUPT_FEED};
  endfunction

  // ==========================================================================
  // In-position judging
  logic inpos_all;
  logic moves_done;
  logic sel_trig;
  always_comb
  begin
    inpos_all = 1'b1;
    for (int i = 0; i < AXES; i++)
      if (err_count_in[i] > inpos_zone_in)
        inpos_all = 1'b0;
    moves_done = &(motion_done_in | ~st.blk.axis_sel[AXES-1:0]);
    sel_trig   = |(trig_rise & st.blk.axis_sel[AXES-1:0]);
  end

  // ==========================================================================
  // Sequencer
  always_comb
  begin
    next_st       = st;
    next_st.done  = 1'b0;
    case (st.seq)
      ST_IDLE:
      begin
        next_st.ready = 1'b1;
        if (block_valid_in && st.ready)
        begin
          next_st.ready     = 1'b0;
          next_st.blk       = block_in;
          next_st.trig_seen = 1'b0;
          next_st.wait_cnt  = '0;
          next_st.blk_mode  = forced_stop(block_in.cmd) ? motion_seq_pkg::MODE_STOP : st.mode;
          case (block_in.cmd)
            motion_seq_pkg::CMD_PASS_MODE:
            begin
              next_st.mode = motion_seq_pkg::MODE_PASS;
              next_st.done = 1'b1;
              next_st.ready = 1'b1;
            end
            motion_seq_pkg::CMD_STOP_MODE:
            begin
              next_st.mode = motion_seq_pkg::MODE_STOP;
              next_st.done = 1'b1;
              next_st.ready = 1'b1;
            end
            motion_seq_pkg::CMD_INPOS_CHECK_OFF:
            begin
              next_st.mode = motion_seq_pkg::MODE_INPOS_OFF;
              next_st.done = 1'b1;
              next_st.ready = 1'b1;
            end
            motion_seq_pkg::CMD_PROGRAM_START, motion_seq_pkg::CMD_UNIT_RESTART:
            begin
              next_st.mode  = motion_seq_pkg::MODE_PASS;
              next_st.abort = 1'b0;
              next_st.done  = 1'b1;
              next_st.ready = 1'b1;
            end
            motion_seq_pkg::CMD_INTERRUPT_FEED:
            begin
              if (!one_hot(block_in.axis_sel[AXES-1:0]))
              begin
                next_st.abort = 1'b1;
                next_st.ready = 1'b1;
              end
              else
              begin
                next_st.seq = ST_FEED_SPEED;
                for (int i = 0; i < AXES; i++)
                begin
                  next_st.drive[i].speed_ctl    = block_in.axis_sel[i];
                  next_st.drive[i].speed_stage2 = 1'b0;
                  next_st.drive[i].pos_ctl      = 1'b0;
                  next_st.drive[i].pos_target   = axis_pos_in[i] + block_in.max_travel;
                end
              end
            end
            default:
            begin
              if (block_in.cmd inside {motion_seq_pkg::CMD_ORIGIN_SEARCH,
                                       motion_seq_pkg::CMD_REFERENCE_ORIGIN_RETURN,
                                       motion_seq_pkg::CMD_WORKPIECE_ORIGIN_RETURN})
                next_st.mode = motion_seq_pkg::MODE_PASS;
              next_st.seq = ST_MOVE;
              for (int i = 0; i < AXES; i++)
              begin
                next_st.drive[i].pos_ctl    = block_in.axis_sel[i];
                next_st.drive[i].speed_ctl  = 1'b0;
                next_st.drive[i].pos_target = block_in.feed_dist;
              end
            end
          endcase
        end
      end
      ST_FEED_SPEED:
      begin
        if (sel_trig && !st.trig_seen)
        begin
          next_st.trig_seen = 1'b1;
          next_st.seq       = ST_FEED_POS;
          for (int i = 0; i < AXES; i++)
          begin
            next_st.drive[i].speed_ctl    = 1'b0;
            next_st.drive[i].speed_stage2 = 1'b0;
            next_st.drive[i].pos_ctl      = st.blk.axis_sel[i];
            next_st.drive[i].pos_target   = axis_pos_in[i] + st.blk.feed_dist;
          end
        end
        else if (moves_done)
        begin
          next_st.seq = ST_SETTLE;
          next_st.drive = '0;
        end
        else
        begin
          for (int i = 0; i < AXES; i++)
            next_st.drive[i].speed_stage2 = st.blk.axis_sel[i] & st.blk.two_stage;
        end
      end
      ST_MOVE, ST_FEED_POS:
      begin
        if (moves_done)
        begin
          next_st.seq   = ST_SETTLE;
          next_st.drive = '0;
        end
      end
      ST_SETTLE:
      begin
        next_st.wait_cnt = st.wait_cnt + 1'b1;
        if ((st.blk_mode == motion_seq_pkg::MODE_PASS) ||
            (st.blk_mode == motion_seq_pkg::MODE_STOP && inpos_all) ||
            (st.blk_mode == motion_seq_pkg::MODE_INPOS_OFF &&
             st.wait_cnt >= motion_seq_pkg::CNT_W'(INPOS_OFF_CYCLES - 1)))
        begin
          next_st.seq   = ST_IDLE;
          next_st.ready = 1'b1;
          if (st.blk.cmd == motion_seq_pkg::CMD_INTERRUPT_FEED && !st.trig_seen &&
              !st.blk.skip_opt)
            next_st.abort = 1'b1;
          else
            next_st.done = 1'b1;
        end
      end
      default:
      begin
        next_st.seq = ST_IDLE;
      end
    endcase
    // Ready waits for idle after an abort
    if (st.abort && next_st.abort)
      next_st.ready = next_st.ready & (st.seq == ST_IDLE);
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      st      <= '0;
      st.mode <= motion_seq_pkg::MODE_PASS;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign block_ready_out = st.ready;
  assign block_done_out  = st.done;
  assign prog_abort_out  = st.abort;
  assign op_mode_out     = st.mode;
  assign drive_out       = st.drive;

  // ==========================================================================
  // Assertions
  sequence settle_inpos_off;
    st.seq == ST_SETTLE && st.blk_mode == motion_seq_pkg::MODE_INPOS_OFF;
  endsequence

  AST_INPOS_OFF_BOUND: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    settle_inpos_off |-> st.wait_cnt < motion_seq_pkg::CNT_W'(INPOS_OFF_CYCLES))
    else $error("in-position off wait too long");

  AST_INPOS_OFF_EXIT: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    settle_inpos_off ##0 (st.wait_cnt >= motion_seq_pkg::CNT_W'(INPOS_OFF_CYCLES - 1))
      |=> st.seq == ST_IDLE)
    else $error("in-position off block did not end");

  AST_STOP_WAITS_INPOS: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (st.seq == ST_SETTLE && st.blk_mode == motion_seq_pkg::MODE_STOP && !inpos_all)
      |=> st.seq == ST_SETTLE)
    else $error("stop mode left before in-position");

  AST_PASS_NO_WAIT: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (st.seq == ST_SETTLE && st.blk_mode == motion_seq_pkg::MODE_PASS) |=> st.seq == ST_IDLE)
    else $error("pass mode waited");

  AST_FORCED_STOP: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (st.seq != ST_IDLE && forced_stop(st.blk.cmd)) |-> st.blk_mode == motion_seq_pkg::MODE_STOP)
    else $error("forced-stop command not in stop mode");

  AST_TRIG_SWITCH: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (st.seq == ST_FEED_SPEED && sel_trig && !st.trig_seen) |=>
      st.seq == ST_FEED_POS && (drive_out[0].speed_ctl == 1'b0))
    else $error("trigger did not switch to position control");

  AST_SINGLE_AXIS: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (st.seq == ST_FEED_SPEED) |-> one_hot(st.blk.axis_sel[AXES-1:0]))
    else $error("interrupt feed on several axes");

  AST_NO_TRIG_ABORT: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (st.seq == ST_SETTLE && next_st.seq == ST_IDLE &&
     st.blk.cmd == motion_seq_pkg::CMD_INTERRUPT_FEED && !st.trig_seen && !st.blk.skip_opt)
      |=> prog_abort_out && !block_done_out)
    else $error("missing trigger not aborted");

  AST_ORIGIN_PASS: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (st.seq == ST_IDLE && st.ready && block_valid_in &&
     block_in.cmd == motion_seq_pkg::CMD_ORIGIN_SEARCH) |=>
      op_mode_out == 2'(motion_seq_pkg::MODE_PASS))
    else $error("origin search did not force pass mode");

  AST_MODE_HOLD: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    !(block_valid_in && st.ready && st.seq == ST_IDLE) |=> $stable(op_mode_out))
    else $error("mode changed without command");

endmodule

// ===== verif/servo_axes_model.sv
// Behavioural servo axes: move timer, error counter decay, position update
`timescale 1ns/100ps
module servo_axes_model #(
  parameter int AXES = 4
) (
  input  wire logic                                    sys_clk_in,
  input  wire logic                                    reset_in,
  input  wire motion_seq_pkg::axis_drive_s [AXES-1:0] drive_in,
  input  wire logic [7:0]                              move_cyc_in,
  output logic [AXES-1:0][motion_seq_pkg::ERR_W-1:0]  err_count_out,
  output logic [AXES-1:0][motion_seq_pkg::DIST_W-1:0] axis_pos_out,
  output logic [AXES-1:0]                              motion_done_out
);
  logic [AXES-1:0][7:0] cnt;
  logic [AXES-1:0][1:0] act_q;
  logic [AXES-1:0][1:0] act;

  // ==========================================================================
  // Motion timing
  always_comb
  begin
    for (int i = 0; i < AXES; i++)
    begin
      act[i] = {drive_in[i].speed_ctl, drive_in[i].pos_ctl};
      motion_done_out[i] = (act[i] != 2'h0) && (act[i] == act_q[i]) && (cnt[i] == 8'h00);
    end
  end

  // Error stays high while driven, then decays slowly past the zone
  always_ff @(posedge sys_clk_in)
  begin
    for (int i = 0; i < AXES; i++)
    begin
      if (reset_in)
      begin
        cnt[i] <= 8'h00;
        act_q[i] <= 2'h0;
        err_count_out[i] <= 16'h0000;
        axis_pos_out[i] <= motion_seq_pkg::DIST_W'(i + 1) << 12;
      end
      else
      begin
        act_q[i] <= act[i];
        if (act[i] != act_q[i])
          cnt[i] <= move_cyc_in;
        else if (cnt[i] != 8'h00)
          cnt[i] <= cnt[i] - 8'h01;
        if (act[i] != 2'h0)
          err_count_out[i] <= 16'h0400;
        else if (err_count_out[i] != 16'h0000)
          err_count_out[i] <= err_count_out[i] - 16'h0010;
        if (motion_done_out[i])
          axis_pos_out[i] <= drive_in[i].pos_target;
      end
    end
  end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the motion sequencer against the servo axes model
`timescale 1ns/100ps
module testbench;
  localparam int AXES = 4;
  localparam int IPC  = 20;
  localparam logic [15:0] ZONE = 16'h0020;
  logic                             sys_clk = 1'b0;
  logic                             reset = 1'b1;
  logic                             block_valid = 1'b0;
  motion_seq_pkg::block_req_s       blk = '0;
  logic [AXES-1:0][15:0]            err_count;
  logic [AXES-1:0][23:0]            axis_pos;
  logic [AXES-1:0]                  motion_done;
  logic [AXES-1:0]                  general = '0;
  logic                             block_ready;
  logic                             block_done;
  logic                             prog_abort;
  logic [1:0]                       op_mode;
  motion_seq_pkg::axis_drive_s [AXES-1:0] drive;
  logic [7:0]                       move_cyc = 8'h02;
  int                               err_total = 0;
  int                               checked = 0;
  int                               lat;
  int                               total;
  logic [15:0]                      eat;

  always #12.5 sys_clk = ~sys_clk;

  motion_sequencer #(.AXES(AXES), .INPOS_OFF_CYCLES(IPC)) motion_sequencer_inst (
    .sys_clk_in(sys_clk), .reset_in(reset), .block_valid_in(block_valid), .block_in(blk),
    .inpos_zone_in(ZONE), .err_count_in(err_count), .axis_pos_in(axis_pos),
    .motion_done_in(motion_done), .general_in(general), .block_ready_out(block_ready),
    .block_done_out(block_done), .prog_abort_out(prog_abort), .op_mode_out(op_mode),
    .drive_out(drive));

  servo_axes_model #(.AXES(AXES)) servo_axes_model_inst (
    .sys_clk_in(sys_clk), .reset_in(reset), .drive_in(drive), .move_cyc_in(move_cyc),
    .err_count_out(err_count), .axis_pos_out(axis_pos), .motion_done_out(motion_done));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic motion_seq_pkg::block_req_s mk(motion_seq_pkg::cmd_e c, logic [3:0] s,
                                                    logic [1:0] f);
    mk = '{c, s, f[1], f[0], 24'h000064, 24'h0001F4};
  endfunction

  task automatic send(input motion_seq_pkg::block_req_s r);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (block_ready !== 1'b1 && n < 500);
    check(n < 500, 1, "block never accepted");
    blk = r;
    block_valid = 1'b1;
    @(negedge sys_clk);
    block_valid = 1'b0;
  endtask

  // Waits for completion or abort, noting latency from motion done
  task automatic fin();
    int md;
    total = 0;
    md = -1;
    while (block_done !== 1'b1 && prog_abort !== 1'b1 && total < 3000)
    begin
      if (md < 0 && motion_done != '0)
        md = total;
      @(negedge sys_clk);
      total++;
    end
    check(total < 3000, 1, "block never ended");
    lat = total - md;
    eat = 16'h0000;
    for (int i = 0; i < AXES; i++)
      if (err_count[i] > eat)
        eat = err_count[i];
  endtask

  task automatic run(input motion_seq_pkg::block_req_s r);
    send(r);
    fin();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_modes();
    motion_seq_pkg::cmd_e cm[3];
    motion_seq_pkg::block_req_s r;
    cm = '{motion_seq_pkg::CMD_STOP_MODE, motion_seq_pkg::CMD_INPOS_CHECK_OFF,
           motion_seq_pkg::CMD_PASS_MODE};
    for (int i = 0; i < 3; i++)
    begin
      run(mk(cm[i], 4'h0, 2'b00));
      check(total <= 2, 1, "mode command slow");
      check(op_mode, (i + 1) % 3, "mode not set");
      run(mk(motion_seq_pkg::CMD_LINEAR, 4'h1, 2'b00));
      check(op_mode, (i + 1) % 3, "mode not kept");
      if (i == 0)
        check(eat <= ZONE, 1, "stop mode did not wait for zone");
      if (i == 1)
        check(lat <= IPC + 3, 1, "check off mode too slow");
      if (i == 1)
        check(eat > ZONE, 1, "check off mode judged zone");
      if (i == 2)
        check(lat <= 3 && eat > ZONE, 1, "pass mode waited");
    end
    r = mk(motion_seq_pkg::CMD_TRAVERSE, 4'h2, 2'b00);
    r.feed_dist = 24'h008CA0;
    run(r);
    check(lat <= 3 && prog_abort === 1'b0, 1, "traverse in pass mode");
  endtask

  task automatic t_forced();
    motion_seq_pkg::cmd_e cm[5];
    cm = '{motion_seq_pkg::CMD_RAPID_POSITIONING, motion_seq_pkg::CMD_SPEED_CONTROL,
           motion_seq_pkg::CMD_ORIGIN_SEARCH, motion_seq_pkg::CMD_REFERENCE_ORIGIN_RETURN,
           motion_seq_pkg::CMD_WORKPIECE_ORIGIN_RETURN};
    for (int i = 0; i < 5; i++)
    begin
      run(mk(i < 2 ? motion_seq_pkg::CMD_PASS_MODE : motion_seq_pkg::CMD_STOP_MODE, 4'h0,
             2'b00));
      run(mk(cm[i], 4'h4, 2'b00));
      check(eat <= ZONE, 1, "forced stop mode missed");
      check(op_mode, 0, "mode after command");
    end
    run(mk(motion_seq_pkg::CMD_STOP_MODE, 4'h0, 2'b00));
    run(mk(motion_seq_pkg::CMD_UNIT_RESTART, 4'h0, 2'b00));
    check(op_mode, 0, "restart did not force pass");
  endtask

  task automatic t_irq(input int i, input logic [1:0] f, input logic trig);
    logic [23:0] pos0;
    pos0 = axis_pos[i];
    send(mk(motion_seq_pkg::CMD_INTERRUPT_FEED, 4'h1 << i, f));
    repeat (2) @(negedge sys_clk);
    check({drive[i].speed_ctl, drive[i].pos_ctl}, 2'b10, "no speed phase");
    check(drive[i].speed_stage2, f[1], "speed stage select");
    if (trig)
    begin
      general[(i + 1) % AXES] = 1'b1;
      repeat (6) @(negedge sys_clk);
      check(drive[i].pos_ctl, 0, "wrong input triggered");
      general = '0;
      general[i] = 1'b1;
      repeat (2) @(negedge sys_clk);
      general[i] = 1'b0;
      repeat (4) @(negedge sys_clk);
      check(drive[i].pos_ctl, 1, "no position phase");
      check(drive[i].pos_target, pos0 + 24'h000064, "feed target");
      general[i] = 1'b1;
      repeat (2) @(negedge sys_clk);
      general[i] = 1'b0;
      repeat (4) @(negedge sys_clk);
      check(drive[i].pos_target, pos0 + 24'h000064, "late trigger taken");
    end
    else
      check(drive[i].pos_target, pos0 + 24'h0001F4, "travel limit target");
    fin();
    check(prog_abort, !(trig | f[0]), "abort outcome");
    check(block_done, trig | f[0], "done outcome");
    check(eat <= ZONE, 1, "feed not in stop mode");
    run(mk(motion_seq_pkg::CMD_PROGRAM_START, 4'h0, 2'b00));
    check({prog_abort, op_mode}, 3'b000, "program start state");
  endtask

  task automatic t_multi();
    send(mk(motion_seq_pkg::CMD_INTERRUPT_FEED, 4'h3, 2'b00));
    repeat (4) @(negedge sys_clk);
    check(prog_abort, 1, "multi-axis feed accepted");
    check(drive[0].speed_ctl | drive[1].speed_ctl, 0, "multi-axis feed moved");
    run(mk(motion_seq_pkg::CMD_PROGRAM_START, 4'h0, 2'b00));
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    repeat (3) @(negedge sys_clk);
    check({block_ready, prog_abort, op_mode}, 4'b1000, "state after reset");
    t_modes();
    t_forced();
    move_cyc = 8'h1E;
    for (int i = 0; i < AXES; i++)
      t_irq(i, 2'b00, 1'b1);
    t_irq(1, 2'b10, 1'b1);
    t_irq(2, 2'b01, 1'b0);
    t_irq(3, 2'b00, 1'b0);
    t_multi();
    give_verdict();
  end

  initial
  begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end
endmodule
